// *** rtl/albu_params.svh ***
/*
  Constants of the serial unit with sync-break support: oversampling, frame sizes and field codes.
  Assumes inclusion by bare name from the design modules; definitions only.
*/
`ifndef ALBU_PARAMS_SVH
`define ALBU_PARAMS_SVH
`define ALBU_OVS_LAST    4'hF
`define ALBU_START_MID   4'h7
`define ALBU_DATA_LAST   4'h7
`define ALBU_BRK_TX_SH   16'hE000
`define ALBU_BRK_TX_BITS 4'hE
`define ALBU_BRK_RX_MIN  8'hB0
`define ALBU_BRK_LEN_MAX 8'hFF
`define ALBU_BITS_NOPAR  4'hA
`define ALBU_BITS_PAR    4'hB
`define ALBU_PAR_EVEN    2'h2
`define ALBU_PAR_ODD     2'h3
`define ALBU_ORDER_LSB   1'h1
`endif

// *** rtl/albu_pkg.sv ***
/*
  Types of the serial unit: state encodings and the packed state records.
  Assumes no other package.
*/
package albu_pkg;
  typedef enum logic [1:0] {
    ALBU_TX_IDLE = 2'h0,
    ALBU_TX_LOAD = 2'h1,
    ALBU_TX_SEND = 2'h2
  } albu_tx_state_type;

  typedef enum logic [2:0] {
    ALBU_RX_IDLE  = 3'h0,
    ALBU_RX_START = 3'h1,
    ALBU_RX_DATA  = 3'h2,
    ALBU_RX_PAR   = 3'h3,
    ALBU_RX_STOP  = 3'h4,
    ALBU_RX_BRK   = 3'h5
  } albu_rx_state_type;

  typedef struct packed {
    albu_tx_state_type tst;
    logic [7:0]        tbuf;
    logic              bf;
    logic              sf;
    logic [15:0]       sh;
    logic [3:0]        nbits;
    logic [3:0]        tsub;
    logic              tbrk_pend;
    logic              tbrk_act;
    logic              tdone;
    logic              txd;
    albu_rx_state_type rs;
    logic [3:0]        rsub;
    logic [3:0]        rcnt;
    logic [7:0]        rsh;
    logic              rpar;
    logic [7:0]        rbuf;
    logic              full;
    logic              pe;
    logic              fe;
    logic              oe;
    logic              armed;
    logic              rbrk_pend;
    logic [7:0]        brk_len;
    logic              brk_flag;
    logic              rdone;
    logic              rerr;
  } albu_state_type;

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } albu_tick_state_type;
endpackage

// *** rtl/albu_tick.sv ***
/*
  Oversampling tick generator: one pulse every divisor clocks while running.
  Assumes divisor stable while running; 0 and 1 both give a tick every clock.
*/
module albu_tick (
  input  wire logic mclk_in,
  input  wire logic srst_in,
  input  wire logic ce_in,
  input  wire logic run_in,
  albu_tick_if.gen  tk
);
  albu_pkg::albu_tick_state_type s, next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (!run_in) begin
      next_s.cnt = 16'h0000;
    end else if (s.cnt + 16'h0001 >= tk.divisor) begin
      next_s.cnt = 16'h0000;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 16'h0001;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      s <= '0;
    end else if (ce_in) begin
      s <= next_s;
    end
  end

  assign tk.tick = s.tick;

  chk_tick_gap: assert property (@(posedge mclk_in) disable iff (srst_in || !ce_in)
    (s.tick && tk.divisor > 16'h0001 && run_in) |=> !s.tick)
    else $error("tick pulses back to back");
endmodule

// *** rtl/albu_tick_if.sv ***
/*
  Carrier between the top and its oversampling tick generator.
  Assumes one generator and one user.
*/
interface albu_tick_if;
  logic [15:0] divisor;
  logic        tick;
  modport gen (input divisor, output tick);
  modport use_side (output divisor, input tick);
endinterface

// *** rtl/albu_top.sv ***
/*
  Asynchronous serial unit with sync break send and detect, 16x oversampling.
  Assumes control bits are plain ports held stable per software sequencing; rxd_in already synchronous.
*/
`include "albu_params.svh"
module albu_top (
  input  wire logic       mclk_in,
  input  wire logic       srst_in,
  input  wire logic       ce_in,
  input  wire logic       unit_power_bit_in,
  input  wire logic       tx_enable_bit_in,
  input  wire logic       rx_enable_bit_in,
  input  wire logic       bit_order_select_in,
  input  wire logic       tx_level_invert_in,
  input  wire logic [1:0] parity_mode_in,
  input  wire logic       two_stop_in,
  input  wire logic [15:0] baud_div_in,
  input  wire logic       tx_buffer_we_in,
  input  wire logic [7:0] tx_buffer_in,
  input  wire logic       break_tx_trigger_set_in,
  input  wire logic       break_rx_trigger_set_in,
  input  wire logic       rx_error_status_rd_in,
  input  wire logic       rx_buffer_rd_in,
  input  wire logic       rxd_in,
  output logic            txd_out,
  output logic            tx_buffer_full_flag_out,
  output logic            tx_shift_busy_flag_out,
  output logic            tx_done_interrupt_out,
  output logic            break_tx_trigger_out,
  output logic            break_rx_trigger_out,
  output logic            break_rx_flag_out,
  output logic [7:0]      rx_buffer_out,
  output logic            parity_err_out,
  output logic            framing_err_out,
  output logic            overrun_err_out,
  output logic            rx_done_interrupt_out,
  output logic            rx_error_interrupt_out
);
  albu_pkg::albu_state_type s, next_s;
  albu_tick_if tk ();
  logic tick;
  logic use_par;
  logic pe_now;
  logic tx_end;
  logic frame_end;

  assign tk.divisor = baud_div_in;
  assign tick = tk.tick;
  assign use_par = parity_mode_in[1];

  albu_tick u_tick (
    .mclk_in (mclk_in),
    .srst_in (srst_in),
    .ce_in   (ce_in),
    .run_in  (unit_power_bit_in),
    .tk      (tk.gen)
  );

  function automatic logic [7:0] albu_order(input logic [7:0] d, input logic lsb);
    logic [7:0] r;
    r = d;
    if (lsb != `ALBU_ORDER_LSB) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = d[7 - i];
      end
    end
    return r;
  endfunction

  function automatic logic albu_parity(input logic [7:0] d, input logic [1:0] mode);
    return (mode == `ALBU_PAR_ODD) ? ~^d : ^d;
  endfunction

  assign tx_end = s.tst == albu_pkg::ALBU_TX_SEND && tick && s.tsub == `ALBU_OVS_LAST && s.nbits == 4'h1;
  assign frame_end = s.rs == albu_pkg::ALBU_RX_STOP && tick && s.rsub == `ALBU_OVS_LAST;
  assign pe_now = use_par && (s.rpar != albu_parity(s.rsh, parity_mode_in));

  always_comb begin
    next_s = s;
    next_s.tdone = 1'b0;
    next_s.rdone = 1'b0;
    next_s.rerr = 1'b0;

    if (tx_buffer_we_in && tx_enable_bit_in) begin
      next_s.tbuf = albu_order(tx_buffer_in, bit_order_select_in);
      next_s.bf = 1'b1;
    end
    if (break_tx_trigger_set_in && tx_enable_bit_in) begin
      next_s.tbrk_pend = 1'b1;
    end
    case (s.tst)
      albu_pkg::ALBU_TX_IDLE: begin
        if (s.tbrk_pend) begin
          next_s.sh = `ALBU_BRK_TX_SH;
          next_s.nbits = `ALBU_BRK_TX_BITS;
          next_s.tsub = 4'h0;
          next_s.sf = 1'b1;
          next_s.tbrk_act = 1'b1;
          next_s.tst = albu_pkg::ALBU_TX_SEND;
        end else if (s.bf) begin
          // flags go 10 to 11 first
          next_s.sf = 1'b1;
          next_s.tst = albu_pkg::ALBU_TX_LOAD;
        end
      end
      albu_pkg::ALBU_TX_LOAD: begin
        // then 11 to 01; a write this cycle keeps the buffer full
        next_s.bf = tx_buffer_we_in && tx_enable_bit_in;
        next_s.sh = 16'hFFFF;
        next_s.sh[0] = 1'b0;
        next_s.sh[8:1] = s.tbuf;
        if (use_par) begin
          next_s.sh[9] = albu_parity(s.tbuf, parity_mode_in);
        end
        next_s.nbits = (use_par ? `ALBU_BITS_PAR : `ALBU_BITS_NOPAR) + {3'h0, two_stop_in};
        next_s.tsub = 4'h0;
        next_s.tst = albu_pkg::ALBU_TX_SEND;
      end
      albu_pkg::ALBU_TX_SEND: begin
        if (tick) begin
          next_s.tsub = s.tsub + 4'h1;
          if (s.tsub == `ALBU_OVS_LAST) begin
            next_s.sh = {1'b1, s.sh[15:1]};
            next_s.nbits = s.nbits - 4'h1;
          end
        end
        if (tx_end) begin
          next_s.tst = albu_pkg::ALBU_TX_IDLE;
          next_s.sf = 1'b0;
          next_s.tdone = 1'b1;
          // trigger drops when the break field ends
          if (s.tbrk_act) begin
            next_s.tbrk_pend = 1'b0;
            next_s.tbrk_act = 1'b0;
          end
        end
      end
      default: next_s.tst = albu_pkg::ALBU_TX_IDLE;
    endcase
    if (!tx_enable_bit_in) begin
      next_s.tst = albu_pkg::ALBU_TX_IDLE;
      next_s.bf = 1'b0;
      next_s.sf = 1'b0;
      next_s.tbrk_pend = 1'b0;
      next_s.tbrk_act = 1'b0;
    end
    next_s.txd = (next_s.tst == albu_pkg::ALBU_TX_SEND ? next_s.sh[0] : 1'b1) ^ tx_level_invert_in;

    if (break_rx_trigger_set_in && rx_enable_bit_in) begin
      next_s.rbrk_pend = 1'b1;
    end
    // status read arms the clear, buffer read completes it
    if (rx_error_status_rd_in) begin
      next_s.armed = s.pe || s.fe || s.oe;
    end
    if (rx_buffer_rd_in) begin
      next_s.full = 1'b0;
      if (s.armed) begin
        next_s.pe = 1'b0;
        next_s.fe = 1'b0;
        next_s.oe = 1'b0;
        next_s.armed = 1'b0;
      end
    end
    if (tick) begin
      next_s.rsub = s.rsub + 4'h1;
    end
    case (s.rs)
      albu_pkg::ALBU_RX_IDLE: begin
        next_s.rsub = 4'h0;
        next_s.brk_len = 8'h00;
        if (!rxd_in) begin
          next_s.rs = s.rbrk_pend ? albu_pkg::ALBU_RX_BRK : albu_pkg::ALBU_RX_START;
        end
      end
      albu_pkg::ALBU_RX_START: begin
        if (tick && s.rsub == `ALBU_START_MID) begin
          next_s.rsub = 4'h0;
          next_s.rcnt = 4'h0;
          next_s.rs = rxd_in ? albu_pkg::ALBU_RX_IDLE : albu_pkg::ALBU_RX_DATA;
        end
      end
      albu_pkg::ALBU_RX_DATA: begin
        if (tick && s.rsub == `ALBU_OVS_LAST) begin
          next_s.rsh = {rxd_in, s.rsh[7:1]};
          next_s.rcnt = s.rcnt + 4'h1;
          if (s.rcnt == `ALBU_DATA_LAST) begin
            next_s.rs = use_par ? albu_pkg::ALBU_RX_PAR : albu_pkg::ALBU_RX_STOP;
          end
        end
      end
      albu_pkg::ALBU_RX_PAR: begin
        if (tick && s.rsub == `ALBU_OVS_LAST) begin
          next_s.rpar = rxd_in;
          next_s.rs = albu_pkg::ALBU_RX_STOP;
        end
      end
      albu_pkg::ALBU_RX_STOP: begin
        // only the first stop bit is looked at
        if (frame_end) begin
          next_s.rs = albu_pkg::ALBU_RX_IDLE;
          // pending data or uncleared errors turn the new byte into an overrun
          if (next_s.full || next_s.pe || next_s.fe || next_s.oe) begin
            next_s.oe = 1'b1;
          end else begin
            next_s.rbuf = albu_order(s.rsh, bit_order_select_in);
            next_s.full = 1'b1;
          end
          next_s.pe = next_s.pe || pe_now;
          next_s.fe = next_s.fe || !rxd_in;
          next_s.rerr = (next_s.oe && !s.oe) || pe_now || !rxd_in;
          next_s.rdone = 1'b1;
        end
      end
      albu_pkg::ALBU_RX_BRK: begin
        if (tick && !rxd_in && s.brk_len != `ALBU_BRK_LEN_MAX) begin
          next_s.brk_len = s.brk_len + 8'h01;
        end
        if (tick && rxd_in) begin
          next_s.rs = albu_pkg::ALBU_RX_IDLE;
          if (s.brk_len >= `ALBU_BRK_RX_MIN) begin
            // trigger clears itself on a good break
            next_s.rbrk_pend = break_rx_trigger_set_in;
            next_s.brk_flag = 1'b1;
            next_s.rdone = 1'b1;
          end else begin
            // short low keeps break mode and the flag untouched
            next_s.rerr = 1'b1;
          end
        end
      end
      default: next_s.rs = albu_pkg::ALBU_RX_IDLE;
    endcase
    if (!rx_enable_bit_in) begin
      next_s.rs = albu_pkg::ALBU_RX_IDLE;
      next_s.rbrk_pend = 1'b0;
    end
    // Power off is a full unit reset, so stale flags never survive a restart
    if (!unit_power_bit_in) begin
      next_s = '0;
      next_s.txd = ~tx_level_invert_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      s <= '0;
      s.txd <= 1'b1;
    end else if (ce_in) begin
      s <= next_s;
    end
  end

  assign txd_out = s.txd;
  assign tx_buffer_full_flag_out = s.bf;
  assign tx_shift_busy_flag_out = s.sf;
  assign tx_done_interrupt_out = s.tdone;
  assign break_rx_trigger_out = 1'b0;
  assign break_tx_trigger_out = 1'b0;
  assign break_rx_flag_out = s.brk_flag;
  assign rx_buffer_out = s.rbuf;
  assign parity_err_out = s.pe;
  assign framing_err_out = s.fe;
  assign overrun_err_out = s.oe;
  assign rx_done_interrupt_out = s.rdone;
  assign rx_error_interrupt_out = s.rerr;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in || !ce_in || !unit_power_bit_in);

  chk_trig_read_rx: assert property (break_rx_trigger_out == 1'b0) else $error("rx trigger reads 1");
  chk_trig_read_tx: assert property (break_tx_trigger_out == 1'b0) else $error("tx trigger reads 1");
  chk_brk_rx_clear: assert property ((s.rs == albu_pkg::ALBU_RX_BRK && tick && rxd_in && rx_enable_bit_in
    && s.brk_len >= `ALBU_BRK_RX_MIN && !break_rx_trigger_set_in) |=> !s.rbrk_pend && s.brk_flag && s.rdone)
    else $error("break rx trigger not cleared");
  chk_brk_tx_clear: assert property ((tx_end && s.tbrk_act && tx_enable_bit_in)
    |=> !s.tbrk_pend && tx_done_interrupt_out && !s.sf) else $error("break tx trigger not cleared");
  chk_flag_step: assert property ((s.tst == albu_pkg::ALBU_TX_IDLE && s.bf && !s.tbrk_pend && tx_enable_bit_in
    && !break_tx_trigger_set_in) |=> (s.bf && s.sf) ##1 (s.sf && (!s.bf || $past(tx_buffer_we_in))))
    else $error("flag pair step wrong");
  chk_err_persist: assert property ((s.fe && !s.armed && !rx_error_status_rd_in && rx_enable_bit_in)
    |=> s.fe) else $error("error cleared without status read");
  chk_err_clear: assert property ((s.armed && rx_buffer_rd_in && !frame_end && rx_enable_bit_in)
    |=> !s.pe && !s.fe && !s.oe) else $error("ordered read did not clear errors");
  chk_one_stop: assert property ((frame_end && rx_enable_bit_in) |=> s.rs == albu_pkg::ALBU_RX_IDLE)
    else $error("receiver waited past first stop bit");
  chk_overrun_drop: assert property ((frame_end && rx_enable_bit_in && s.full && !rx_buffer_rd_in)
    |=> s.oe && s.rbuf == $past(s.rbuf)) else $error("overrun byte stored");
  chk_brk_rx_fail: assert property ((s.rs == albu_pkg::ALBU_RX_BRK && tick && rxd_in && rx_enable_bit_in
    && s.brk_len < `ALBU_BRK_RX_MIN) |=> s.rbrk_pend && s.brk_flag == $past(s.brk_flag) && s.rerr)
    else $error("break rx failure left break mode");

  cov_tx_frame: cover property (tx_end && !s.tbrk_act);
  cov_brk_tx: cover property (tx_end && s.tbrk_act);
  cov_brk_rx: cover property (s.rs == albu_pkg::ALBU_RX_BRK ##1 s.brk_flag);
  cov_overrun: cover property ($rose(s.oe));
endmodule

// *** test/albu_remote.sv ***
/*
  Remote serial node on the far side of the line: sends bit patterns, decodes frames seen on txd.
  Assumes 16 clocks a bit (divisor 1), 8 data bits LSB first, no parity on the decoded side.
*/
module albu_remote (
  input  wire logic mclk_in,
  input  wire logic txd_in,
  output logic      rxd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx_q [$];
  logic [7:0] cap;
  initial rxd_out = 1'b1;
  // Bit patterns always end on a high bit, so the line rests idle high
  task automatic send_bits(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk_in);
      rxd_out <= bits[i];
      repeat (15) @(posedge mclk_in);
    end
  endtask
  // Mid-bit sampling; a frame with a low stop is dropped, as a real node would
  initial begin
    forever begin
      wait (txd_in === 1'b1);
      wait (txd_in === 1'b0);
      repeat (8) @(posedge mclk_in);
      for (int i = 0; i < 8; i++) begin
        repeat (16) @(posedge mclk_in);
        cap[i] = txd_in;
      end
      repeat (16) @(posedge mclk_in);
      if (txd_in === 1'b1) rx_q.push_back(cap);
    end
  end
endmodule

// *** test/albu_top_tb.sv ***
/*
  Self-checking bench of the serial unit: tx flags, break send and detect, rx errors, power sequencing.
  Assumes divisor 1 (16 clocks a bit) and the remote node model on the serial lines.
*/
module albu_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk_in = 1'b0;
  logic       srst_in = 1'b1;
  logic       pwr = 1'b0, txe = 1'b0, rxe = 1'b0, order = 1'b1, inv = 1'b0, two_stop = 1'b1;
  logic       we = 1'b0, btx = 1'b0, brx = 1'b0, srd = 1'b0, brd = 1'b0;
  logic [1:0] par = 2'h0;
  logic [7:0] tdata = 8'h00;
  wire        rxd, txd, bf, sf, tx_done, btx_rd, brx_rd, brk_flag, pe, fe, oe, rx_done, rx_err;
  wire  [7:0] rbuf;
  int         mismatches = 0, check_count = 0, n_wait;

  albu_top u_albu_top (.mclk_in(mclk_in), .srst_in(srst_in), .ce_in(1'b1), .unit_power_bit_in(pwr),
    .tx_enable_bit_in(txe), .rx_enable_bit_in(rxe), .bit_order_select_in(order), .tx_level_invert_in(inv),
    .parity_mode_in(par), .two_stop_in(two_stop), .baud_div_in(16'h0001), .tx_buffer_we_in(we),
    .tx_buffer_in(tdata), .break_tx_trigger_set_in(btx), .break_rx_trigger_set_in(brx),
    .rx_error_status_rd_in(srd), .rx_buffer_rd_in(brd), .rxd_in(rxd), .txd_out(txd),
    .tx_buffer_full_flag_out(bf), .tx_shift_busy_flag_out(sf), .tx_done_interrupt_out(tx_done),
    .break_tx_trigger_out(btx_rd), .break_rx_trigger_out(brx_rd), .break_rx_flag_out(brk_flag),
    .rx_buffer_out(rbuf), .parity_err_out(pe), .framing_err_out(fe), .overrun_err_out(oe),
    .rx_done_interrupt_out(rx_done), .rx_error_interrupt_out(rx_err));
  albu_remote u_albu_remote (.mclk_in(mclk_in), .txd_in(txd), .rxd_out(rxd));

  initial forever #2 mclk_in = ~mclk_in;

  task results;
    if (mismatches == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  task pulse(input int k);
    @(posedge mclk_in);
    case (k)
      0: we <= 1'b1;
      1: btx <= 1'b1;
      2: brx <= 1'b1;
      3: srd <= 1'b1;
      default: brd <= 1'b1;
    endcase
    @(posedge mclk_in);
    {we, btx, brx, srd, brd} <= 5'h00;
    #1;
  endtask

  function logic sel(input int k);
    case (k)
      0: sel = tx_done;
      1: sel = rx_done;
      2: sel = rx_err;
      3: sel = ~txd;
      default: sel = ~bf;
    endcase
  endfunction

  task wait_for(input int k, input int lim);
    n_wait = 0;
    while (sel(k) !== 1'b1 && n_wait < lim) begin
      tick(1);
      n_wait++;
    end
    if (n_wait >= lim) chk("wait event", 16'h0001, 16'h0000);
  endtask

  task rx_send(input logic [15:0] bits, input int n, input int k);
    fork
      u_albu_remote.send_bits(bits, n);
      wait_for(k, 400);
    join
  endtask

  task s_reset;
    chk("txd idle", 16'h0001, txd);
    chk("flags", 16'h0000, {bf, sf, brk_flag, pe, fe, oe});
    chk("rx buffer", 16'h0000, rbuf);
    chk("rx trigger", 16'h0000, brx_rd);
    chk("tx trigger", 16'h0000, btx_rd);
  endtask

  task s_cont_tx;
    tdata <= 8'hC3;
    pulse(0);
    chk("flags 10", 16'h0002, {bf, sf});
    tick(1);
    chk("flags 11", 16'h0003, {bf, sf});
    tick(1);
    chk("flags 01", 16'h0001, {bf, sf});
    // next byte only with buffer empty
    wait_for(5, 10);
    tdata <= 8'h5E;
    pulse(0);
    wait_for(0, 400);
    tick(1);
    wait_for(0, 400);
    tick(1);
    chk("flags idle", 16'h0000, {bf, sf});
    chk("tx byte one", 16'h00C3, u_albu_remote.rx_q.size() > 0 ? u_albu_remote.rx_q[0] : 8'h00);
    chk("tx byte two", 16'h005E, u_albu_remote.rx_q.size() > 1 ? u_albu_remote.rx_q[1] : 8'h00);
  endtask

  task s_break_tx;
    int n;
    n = 0;
    // power and enable on, shifter idle
    pulse(1);
    chk("tx trigger", 16'h0000, btx_rd);
    wait_for(3, 20);
    while (txd === 1'b0 && n < 400) begin
      tick(1);
      n++;
    end
    chk("break low clocks", 16'h00D0, n);
    wait_for(0, 40);
    tick(1);
    chk("tx trigger", 16'h0000, btx_rd);
    chk("shift busy", 16'h0000, sf);
  endtask

  task s_rx_frames;
    fork
      begin
        u_albu_remote.send_bits({6'h00, 1'b1, 8'hA5, 1'b0}, 10);
        u_albu_remote.send_bits({6'h00, 1'b1, 8'h3C, 1'b0}, 10);
      end
      begin
        wait_for(1, 400);
        chk("rx byte one", 16'h00A5, rbuf);
        pulse(4);
        wait_for(1, 400);
        chk("rx byte two", 16'h003C, rbuf);
        chk("errors", 16'h0000, {pe, fe, oe});
      end
    join
    pulse(4);
  endtask

  task s_rx_errors;
    rxe <= 1'b0;
    par <= 2'h2;
    tick(2);
    rxe <= 1'b1;
    rx_send({5'h00, 1'b1, 1'b1, 8'h5A, 1'b0}, 11, 1);
    chk("parity error", 16'h0001, pe);
    rx_send({5'h00, 1'b1, 1'b0, 8'h33, 1'b0}, 11, 1);
    chk("overrun", 16'h0001, oe);
    chk("kept byte", 16'h005A, rbuf);
    pulse(4);
    tick(1);
    chk("errors kept", 16'h0005, {pe, fe, oe});
    pulse(3);
    pulse(4);
    tick(1);
    chk("errors cleared", 16'h0000, {pe, fe, oe});
    // Low first stop: framing error kept until the ordered read
    rx_send({4'h0, 1'b1, 1'b0, 1'b0, 8'h33, 1'b0}, 12, 1);
    chk("framing error", 16'h0002, {pe, fe, oe});
    chk("framed byte", 16'h0033, rbuf);
    pulse(4);
    tick(1);
    chk("framing kept", 16'h0002, {pe, fe, oe});
    pulse(3);
    pulse(4);
    tick(1);
    chk("framing cleared", 16'h0000, {pe, fe, oe});
    rxe <= 1'b0;
    par <= 2'h0;
    tick(2);
    rxe <= 1'b1;
  endtask

  task s_break_rx;
    pulse(2);
    rx_send(16'h2000, 14, 1);
    chk("break flag", 16'h0001, brk_flag);
    chk("rx trigger", 16'h0000, brx_rd);
    pulse(2);
    rx_send(16'h0100, 9, 2);
    chk("break flag held", 16'h0001, brk_flag);
    rx_send(16'h2000, 14, 1);
    chk("break rearmed", 16'h0001, brk_flag);
    chk("break not a frame", 16'h0000, fe);
    // A good break disarms break mode, so a plain frame follows
    rx_send({6'h00, 1'b1, 8'h96, 1'b0}, 10, 1);
    chk("frame after break", 16'h0096, rbuf);
  endtask

  task s_power;
    {txe, rxe} <= 2'h0;
    tick(2);
    pwr <= 1'b0;
    tick(2);
    chk("flag after power off", 16'h0000, brk_flag);
    order <= 1'b0;
    inv <= 1'b1;
    tick(1);
    pwr <= 1'b1;
    tick(1);
    {txe, rxe} <= 2'h3;
    tick(2);
    chk("inverted idle", 16'h0000, txd);
    rx_send({6'h00, 1'b1, 8'h01, 1'b0}, 10, 1);
    chk("msb first byte", 16'h0080, rbuf);
  endtask

  initial begin
    #200000;
    mismatches++;
    results;
  end

  initial begin
    repeat (10) @(posedge mclk_in);
    srst_in <= 1'b0;
    tick(2);
    s_reset();
    pwr <= 1'b1;
    tick(1);
    {txe, rxe} <= 2'h3;
    tick(2);
    s_cont_tx();
    s_break_tx();
    s_rx_frames();
    s_rx_errors();
    s_break_rx();
    s_power();
    results;
  end
endmodule
